//--- design/gbi_slave.sv
// Functional notes
// - Control bits 5:4 pick bias 60, 80, 100 (default) or 150 percent.
// - Mode 00 takes the active bank from the two bank pins.
// - Mode 01 takes the active bank from the software bank bits.
// - Mode bit 1 set drives all DACs from the volatile latch.
// - Status reads live load pin in bit 7, bank pins in bits 1:0.
// - Gamma word: first byte bits 9:2, second byte 7:6 bits 1:0, default 8000h.
// - SDA falling while SCL high is a START; address reception follows.
// - SDA rising while SCL high is a STOP; the transfer ends.
// - Repeated START behaves exactly like a START.
// - SDA changes only while SCL low; bits are captured on SCL rise.
// - Outgoing bits are driven at the previous SCL fall.
// - Ninth bit is acknowledge: 0 acknowledges, 1 refuses.
// - Written bytes arrive eight bits, MSB first, then the slave acknowledges, except a data byte refused while load pin high and the update buffer full.
// - Master acknowledges wanted read bytes, refuses the last; slave then releases SDA.
// - First byte after START: slave address in bits 7:1, direction in bit 0.
// - Strap pin low gives address bit 0, high gives 1.
// - Direction 0 is write, 1 is read: C0h and C1h with strap low.
// - Non-matching address: ignore everything, no acknowledge, until next START.
// - Second written byte is the memory address to load.
// - Software bank bits 1:0 at 40h pick bank A to D.
// - With load pin high, acknowledged data updates the DAC; commit follows STOP.
`timescale 1ns/1ps
`default_nettype none
module gbi_slave (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// Serial link pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Strap and control pins
	input  wire logic       addr_strap_pin,
	input  wire logic       load_strobe_pin,
	input  wire logic       bank_pin_low,
	input  wire logic       bank_pin_high,
	// Analog control outputs
	output logic      [7:0] bias_pct,
	output logic      [1:0] active_bank,
	output logic            dac_from_latch,
	output logic      [9:0] gamma_eeprom_word,
	// DAC update stream
	output logic            upd_valid,
	input  wire logic       upd_ready,
	output logic     [15:0] upd_data,
	// Nonvolatile commit
	output logic            eeprom_commit
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic       scl_m_q, scl_s_q, scl_p_q;
	logic       sda_m_q, sda_s_q, sda_p_q;
	logic       ld_m_q, ld_s_q, strap_m_q, strap_s_q;
	logic [1:0] bnk_m_q, bnk_s_q;
	logic       scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
			{ld_m_q, ld_s_q, strap_m_q, strap_s_q} <= 4'h0;
			bnk_m_q <= 2'h0;
			bnk_s_q <= 2'h0;
		end else if (clk_en) begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
			{ld_m_q, ld_s_q}       <= {load_strobe_pin, ld_m_q};
			{strap_m_q, strap_s_q} <= {addr_strap_pin, strap_m_q};
			bnk_m_q <= {bank_pin_high, bank_pin_low};
			bnk_s_q <= bnk_m_q;
		end
	end

	assign scl_rise  = scl_s_q && !scl_p_q;
	assign scl_fall  = !scl_s_q && scl_p_q;
	assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

	// ****************************************
	// Register read mux
	// ****************************************
	logic [7:0]  soft_bank_q, soft_bank_d, control_q, control_d;
	logic [15:0] gamma_q, gamma_d;
	logic [7:0]  mem_ptr_q, mem_ptr_d, rd_data, status_byte;

	always_comb begin
		status_byte = 8'h00;
		status_byte[gbi_pkg::STAT_LOAD_BIT]    = ld_s_q;
		status_byte[gbi_pkg::STAT_BANK_HI_BIT] = bnk_s_q[1];
		status_byte[gbi_pkg::STAT_BANK_LO_BIT] = bnk_s_q[0];
		case (mem_ptr_q)
			gbi_pkg::OFS_SOFT_BANK: rd_data = soft_bank_q;
			gbi_pkg::OFS_CONTROL:   rd_data = control_q;
			gbi_pkg::OFS_STATUS:    rd_data = status_byte;
			gbi_pkg::OFS_GAMMA_HI:  rd_data = gamma_q[15:8];
			gbi_pkg::OFS_GAMMA_LO:  rd_data = gamma_q[7:0];
			default:                rd_data = gbi_pkg::READ_UNMAPPED;
		endcase
	end

	// ****************************************
	// Serial engine
	// ****************************************
	gbi_pkg::gbi_state_e state_q, state_d;
	gbi_pkg::gbi_kind_e  kind_q, kind_d;
	logic [2:0] bitcnt_q, bitcnt_d;
	logic [7:0] shift_q, shift_d;
	logic       rx_full_q, rx_full_d, rnw_q, rnw_d, pull_q, pull_d;
	logic       mack_q, mack_d, wrote_q, wrote_d, commit_q, commit_d;
	logic       push, fifo_in_ready, addr_match;

	// Address in bits 7:1, strap bit last
	assign addr_match = (shift_q[7:1] == {gbi_pkg::SLAVE_ADDR_FIXED, strap_s_q});

	always_comb begin
		state_d     = state_q;
		kind_d      = kind_q;
		bitcnt_d    = bitcnt_q;
		shift_d     = shift_q;
		rx_full_d   = rx_full_q;
		rnw_d       = rnw_q;
		pull_d      = pull_q;
		mack_d      = mack_q;
		wrote_d     = wrote_q;
		commit_d    = 1'b0;
		mem_ptr_d   = mem_ptr_q;
		soft_bank_d = soft_bank_q;
		control_d   = control_q;
		gamma_d     = gamma_q;
		push        = 1'b0;
		if (stop_det) begin
			// Stop ends transfer; commit after stop
			state_d  = gbi_pkg::ST_IDLE;
			pull_d   = 1'b0;
			commit_d = wrote_q;
			wrote_d  = 1'b0;
		end else if (start_det) begin
			state_d   = gbi_pkg::ST_RX;
			kind_d    = gbi_pkg::BK_SLAVE;
			bitcnt_d  = gbi_pkg::FIRST_BIT;
			rx_full_d = 1'b0;
			pull_d    = 1'b0;
		end else begin
			case (state_q)
				gbi_pkg::ST_RX: begin
					if (scl_rise && !rx_full_q) begin
						shift_d  = {shift_q[6:0], sda_s_q};
						bitcnt_d = bitcnt_q + 3'h1;
						if (bitcnt_q == gbi_pkg::LAST_BIT) begin
							rx_full_d = 1'b1;
						end
					end
					if (scl_fall && rx_full_q) begin
						rx_full_d = 1'b0;
						bitcnt_d  = gbi_pkg::FIRST_BIT;
						case (kind_q)
							gbi_pkg::BK_SLAVE: begin
								if (addr_match) begin
									rnw_d   = shift_q[0];
									pull_d  = 1'b1;
									state_d = gbi_pkg::ST_ACK;
								end else begin
									state_d = gbi_pkg::ST_IDLE;
								end
							end
							gbi_pkg::BK_MEMADDR: begin
								mem_ptr_d = shift_q;
								pull_d    = 1'b1;
								state_d   = gbi_pkg::ST_ACK;
							end
							default: begin
								// Full update buffer refuses the byte rather than lose it
								if (ld_s_q && !fifo_in_ready) begin
									state_d = gbi_pkg::ST_IDLE;
								end else begin
									case (mem_ptr_q)
										gbi_pkg::OFS_SOFT_BANK: soft_bank_d = shift_q & gbi_pkg::WMASK_SOFT;
										gbi_pkg::OFS_CONTROL:   control_d = shift_q & gbi_pkg::WMASK_CONTROL;
										gbi_pkg::OFS_GAMMA_HI:  gamma_d[15:8] = shift_q;
										gbi_pkg::OFS_GAMMA_LO:  gamma_d[7:0] = shift_q & gbi_pkg::WMASK_GAMMA_LO;
										default:                gamma_d = gamma_q;
									endcase
									push      = ld_s_q;
									wrote_d   = 1'b1;
									mem_ptr_d = mem_ptr_q + 8'h01;
									pull_d    = 1'b1;
									state_d   = gbi_pkg::ST_ACK;
								end
							end
						endcase
					end
				end
				gbi_pkg::ST_ACK: begin
					// Acknowledge held through the ninth clock
					if (scl_fall) begin
						if (kind_q == gbi_pkg::BK_SLAVE && rnw_q) begin
							shift_d   = rd_data;
							pull_d    = !rd_data[7];
							mem_ptr_d = mem_ptr_q + 8'h01;
							state_d   = gbi_pkg::ST_TX;
						end else begin
							pull_d  = 1'b0;
							state_d = gbi_pkg::ST_RX;
							kind_d  = (kind_q == gbi_pkg::BK_SLAVE) ? gbi_pkg::BK_MEMADDR : gbi_pkg::BK_DATA;
						end
					end
				end
				gbi_pkg::ST_TX: begin
					// Next bit driven at the fall
					if (scl_fall) begin
						if (bitcnt_q == gbi_pkg::LAST_BIT) begin
							pull_d  = 1'b0;
							state_d = gbi_pkg::ST_MACK;
						end else begin
							shift_d  = {shift_q[6:0], 1'b0};
							pull_d   = !shift_q[6];
							bitcnt_d = bitcnt_q + 3'h1;
						end
					end
				end
				gbi_pkg::ST_MACK: begin
					if (scl_rise) begin
						mack_d = !sda_s_q;
					end
					// Refusal ends the read with SDA released
					if (scl_fall) begin
						bitcnt_d = gbi_pkg::FIRST_BIT;
						if (mack_q) begin
							shift_d   = rd_data;
							pull_d    = !rd_data[7];
							mem_ptr_d = mem_ptr_q + 8'h01;
							state_d   = gbi_pkg::ST_TX;
						end else begin
							state_d = gbi_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_d = gbi_pkg::ST_IDLE;
					pull_d  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= gbi_pkg::ST_IDLE;
			kind_q      <= gbi_pkg::BK_SLAVE;
			bitcnt_q    <= gbi_pkg::FIRST_BIT;
			shift_q     <= 8'h00;
			rx_full_q   <= 1'b0;
			rnw_q       <= 1'b0;
			pull_q      <= 1'b0;
			mack_q      <= 1'b0;
			wrote_q     <= 1'b0;
			commit_q    <= 1'b0;
			mem_ptr_q   <= 8'h00;
			soft_bank_q <= gbi_pkg::RST_SOFT_BANK;
			control_q   <= gbi_pkg::RST_CONTROL;
			gamma_q     <= gbi_pkg::RST_GAMMA;
		end else if (clk_en) begin
			state_q     <= state_d;
			kind_q      <= kind_d;
			bitcnt_q    <= bitcnt_d;
			shift_q     <= shift_d;
			rx_full_q   <= rx_full_d;
			rnw_q       <= rnw_d;
			pull_q      <= pull_d;
			mack_q      <= mack_d;
			wrote_q     <= wrote_d;
			commit_q    <= commit_d;
			mem_ptr_q   <= mem_ptr_d;
			soft_bank_q <= soft_bank_d;
			control_q   <= control_d;
			gamma_q     <= gamma_d;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out       = 1'b0;
	assign sda_oe_n      = !pull_q;
	assign eeprom_commit = commit_q;

	// ****************************************
	// Analog control outputs
	// ****************************************
	logic [7:0] bias_pct_q, bias_pct_d;
	logic [1:0] active_bank_q, active_bank_d;
	// Bias and bank outputs lag the control byte by one clock
	logic       latch_q, latch_d;
	logic [1:0] mode;

	assign mode = control_q[gbi_pkg::CTRL_MODE_MSB:gbi_pkg::CTRL_MODE_LSB];

	always_comb begin
		case (control_q[gbi_pkg::CTRL_BIAS_MSB:gbi_pkg::CTRL_BIAS_LSB])
			gbi_pkg::BIAS_60:  bias_pct_d = gbi_pkg::PCT_60;
			gbi_pkg::BIAS_80:  bias_pct_d = gbi_pkg::PCT_80;
			gbi_pkg::BIAS_100: bias_pct_d = gbi_pkg::PCT_100;
			default:           bias_pct_d = gbi_pkg::PCT_150;
		endcase
		// Pins pick bank; software bits otherwise
		active_bank_d = (mode == gbi_pkg::MODE_PINS) ? bnk_s_q : soft_bank_q[1:0];
		latch_d = control_q[gbi_pkg::CTRL_MODE_LATCH];
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bias_pct_q    <= gbi_pkg::PCT_100;
			active_bank_q <= 2'h0;
			latch_q       <= 1'b0;
		end else if (clk_en) begin
			bias_pct_q    <= bias_pct_d;
			active_bank_q <= active_bank_d;
			latch_q       <= latch_d;
		end
	end

	assign bias_pct          = bias_pct_q;
	assign active_bank       = active_bank_q;
	assign dac_from_latch    = latch_q;
	assign gamma_eeprom_word = gamma_q[gbi_pkg::GAMMA_MSB:gbi_pkg::GAMMA_LSB];

	// ****************************************
	// DAC update buffer
	// ****************************************
	gbi_fifo #(
		.WIDTH (gbi_pkg::UPD_WIDTH),
		.DEPTH (gbi_pkg::UPD_DEPTH)
	) u_upd_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({mem_ptr_q, shift_q}),
		.out_valid (upd_valid),
		.out_ready (upd_ready),
		.out_data  (upd_data)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_stop_ends: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && stop_det |=> state_q == gbi_pkg::ST_IDLE && !pull_q && !wrote_q)
		else $error("stop did not end the transfer");
	a_start_restarts: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && start_det && !stop_det |=> state_q == gbi_pkg::ST_RX && kind_q == gbi_pkg::BK_SLAVE
		&& bitcnt_q == gbi_pkg::FIRST_BIT)
		else $error("start did not restart address reception");
	a_miss_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == gbi_pkg::ST_IDLE |-> !pull_q)
		else $error("slave drives sda while idle");
	a_ack_held: assert property (@(posedge clock) disable iff (!reset_n)
		state_q == gbi_pkg::ST_ACK |-> pull_q && bitcnt_q == gbi_pkg::FIRST_BIT)
		else $error("acknowledge not driven low");
	a_nack_release: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && state_q == gbi_pkg::ST_MACK && scl_fall && !mack_q && !start_det && !stop_det
		|=> state_q == gbi_pkg::ST_IDLE ##1 !pull_q)
		else $error("sda not released after refusal");
	a_bias_map: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && control_q[gbi_pkg::CTRL_BIAS_MSB:gbi_pkg::CTRL_BIAS_LSB] == gbi_pkg::BIAS_60
		|=> bias_pct_q == gbi_pkg::PCT_60)
		else $error("bias lookup wrong");
	a_bank_pins: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && mode == gbi_pkg::MODE_PINS |=> active_bank_q == $past(bnk_s_q))
		else $error("bank not taken from pins");
	a_bank_soft: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && mode == gbi_pkg::MODE_SOFT |=> active_bank_q == $past(soft_bank_q[1:0]))
		else $error("bank not taken from software bits");
	a_latch_mode: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && control_q[gbi_pkg::CTRL_MODE_LATCH] |=> dac_from_latch)
		else $error("latch mode not applied");
	a_commit_stop: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(commit_q) |-> $past(stop_det) && $past(wrote_q))
		else $error("commit without a closing stop");
endmodule // gbi_slave
`default_nettype wire

//--- common/gbi_pkg.sv
`default_nettype none
// ****************************************
// Gamma buffer serial slave constants
// ****************************************
package gbi_pkg;
	// Register offsets
	localparam logic [7:0] OFS_SOFT_BANK = 8'h40;
	localparam logic [7:0] OFS_CONTROL   = 8'h48;
	localparam logic [7:0] OFS_STATUS    = 8'h4a;
	localparam logic [7:0] OFS_GAMMA_HI  = 8'h58;
	localparam logic [7:0] OFS_GAMMA_LO  = 8'h59;
	// Reset values and writable bits
	localparam logic [7:0]  RST_SOFT_BANK  = 8'h00;
	localparam logic [7:0]  RST_CONTROL    = 8'h20;
	localparam logic [15:0] RST_GAMMA      = 16'h8000;
	localparam logic [7:0]  WMASK_SOFT     = 8'h03;
	localparam logic [7:0]  WMASK_CONTROL  = 8'h33;
	localparam logic [7:0]  WMASK_GAMMA_LO = 8'hc0;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
	// Field positions
	localparam int CTRL_BIAS_MSB     = 5;
	localparam int CTRL_BIAS_LSB     = 4;
	localparam int CTRL_MODE_MSB     = 1;
	localparam int CTRL_MODE_LSB     = 0;
	localparam int CTRL_MODE_LATCH   = 1;
	localparam int STAT_LOAD_BIT     = 7;
	localparam int STAT_BANK_HI_BIT  = 1;
	localparam int STAT_BANK_LO_BIT  = 0;
	localparam int GAMMA_MSB         = 15;
	localparam int GAMMA_LSB         = 6;
	// Mode and bias encodings
	localparam logic [1:0] MODE_PINS = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] BIAS_60   = 2'h0;
	localparam logic [1:0] BIAS_80   = 2'h1;
	localparam logic [1:0] BIAS_100  = 2'h2;
	localparam logic [7:0] PCT_60    = 8'h3c;
	localparam logic [7:0] PCT_80    = 8'h50;
	localparam logic [7:0] PCT_100   = 8'h64;
	localparam logic [7:0] PCT_150   = 8'h96;
	// Serial link
	localparam logic [5:0] SLAVE_ADDR_FIXED = 6'h30;
	localparam logic [2:0] LAST_BIT         = 3'h7;
	localparam logic [2:0] FIRST_BIT        = 3'h0;
	// Update stream buffer
	localparam int UPD_WIDTH = 16;
	localparam int UPD_DEPTH = 8;
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} gbi_state_e;
	typedef enum logic [1:0] {BK_SLAVE, BK_MEMADDR, BK_DATA} gbi_kind_e;
endpackage
`default_nettype wire

//--- design/gbi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module gbi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic             push, pop;

	assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem_q[rd_q[AW-1:0]];
	assign push      = clk_en && in_valid && in_ready;
	assign pop       = clk_en && out_valid && out_ready;

	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage has no reset; words are only read once written
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	a_fifo_head_held: assert property (@(posedge clock) disable iff (!reset_n)
		clk_en && out_valid && !out_ready |=> out_valid && out_data == $past(out_data))
		else $error("fifo head changed before it was taken");
endmodule // gbi_fifo
`default_nettype wire

//--- tb/gbi_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Serial bus master model
// ****************************************
module gbi_master (
	// Bus pins
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end
	// start or repeated start
	// Waits out the slave's late acknowledge release before raising the clock
	task automatic start();
		sda_low = 1'b0;
		#160 scl = 1'b1;
		#80 sda_low = 1'b1;
		#80 scl = 1'b0;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#80 scl = 1'b1;
		#80 sda_low = 1'b0;
		#160;
	endtask
	task automatic bit_xfer(input logic b, output logic r);
		#80 sda_low = ~b;
		#80 scl = 1'b1;
		#120 r = sda;
		#40 scl = 1'b0;
	endtask
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, ack);
	endtask
	// acknowledge all but the last byte
	task automatic byte_r(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, r);
			d[i] = r;
		end
		bit_xfer(last, r);
	endtask
endmodule // gbi_master
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clock, reset_n, clk_en, scl_in, sda_in, sda_low, addr_strap_pin, load_strobe_pin;
	logic        bank_pin_low, bank_pin_high, upd_ready, sda_out, sda_oe_n, dac_from_latch;
	logic        upd_valid, eeprom_commit, a1, a2, a3;
	logic [7:0]  bias_pct, d0, d1;
	logic [1:0]  active_bank;
	logic [9:0]  gamma_eeprom_word;
	logic [15:0] upd_data;
	int          mismatches, n_compared, n_commit;

	gbi_slave gbi_slave_i (.clock, .reset_n, .clk_en, .scl_in, .sda_in, .sda_out, .sda_oe_n,
		.addr_strap_pin, .load_strobe_pin, .bank_pin_low, .bank_pin_high, .bias_pct, .active_bank,
		.dac_from_latch, .gamma_eeprom_word, .upd_valid, .upd_ready, .upd_data, .eeprom_commit);
	gbi_master gbi_master_i (.scl(scl_in), .sda_low, .sda(sda_in));
	// Pull-up wins unless someone pulls low
	assign sda_in = !sda_low && (sda_oe_n || sda_out);

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (eeprom_commit === 1'b1) n_commit++;
	end
	task automatic test_done();
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic sync();
		@(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc0, a1);
		gbi_master_i.byte_w(a, a2);
		gbi_master_i.byte_w(d, a3);
		gbi_master_i.stop();
		chk("write acks", 16'h0, {a1, a2, a3});
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc0, a1);
		gbi_master_i.byte_w(a, a2);
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc1, a3);
		gbi_master_i.byte_r(1'b1, d);
		gbi_master_i.stop();
		chk("read acks", 16'h0, {a1, a2, a3});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("bias_pct", gbi_pkg::PCT_100, bias_pct);
		chk("gamma word", 16'h200, gamma_eeprom_word);
		rd(8'h48, d0);
		chk("control", 16'h20, d0);
		rd(8'h58, d0);
		rd(8'h59, d1);
		chk("gamma bytes", 16'h8000, {d0, d1});
	endtask
	task automatic t_bias();
		logic [7:0] pct [4];
		int         c;
		pct = '{gbi_pkg::PCT_60, gbi_pkg::PCT_80, gbi_pkg::PCT_100, gbi_pkg::PCT_150};
		for (int k = 0; k < 4; k++) begin
			c = n_commit;
			wr(8'h48, 8'(k << 4));
			chk("bias_pct", pct[k], bias_pct);
			chk("commits", 16'(c + 1), 16'(n_commit));
		end
	endtask
	task automatic t_bank();
		bank_pin_high = 1'b1;
		wr(8'h48, 8'h00);
		repeat (4) sync();
		chk("pin bank", 16'h2, active_bank);
		chk("latch", 16'h0, dac_from_latch);
		wr(8'h40, 8'h03);
		wr(8'h48, 8'h01);
		chk("soft bank", 16'h3, active_bank);
		wr(8'h40, 8'h01);
		chk("soft bank", 16'h1, active_bank);
		wr(8'h48, 8'h02);
		chk("latch", 16'h1, dac_from_latch);
		wr(8'h48, 8'h03);
		chk("latch", 16'h1, dac_from_latch);
		wr(8'h48, 8'h20);
		bank_pin_high = 1'b0;
	endtask
	task automatic t_status();
		load_strobe_pin = 1'b1;
		bank_pin_low = 1'b1;
		repeat (4) sync();
		rd(8'h4a, d0);
		chk("status", 16'h81, d0);
		load_strobe_pin = 1'b0;
		bank_pin_low = 1'b0;
	endtask
	task automatic t_gamma();
		sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc0, a1);
		gbi_master_i.byte_w(8'h58, a2);
		gbi_master_i.byte_w(8'ha5, a3);
		gbi_master_i.byte_w(8'hff, a3);
		gbi_master_i.stop();
		chk("gamma word", 16'h297, gamma_eeprom_word);
		sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc0, a1);
		gbi_master_i.byte_w(8'h58, a2);
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc1, a3);
		gbi_master_i.byte_r(1'b0, d0);
		gbi_master_i.byte_r(1'b1, d1);
		chk("sda released", 16'h1, sda_oe_n);
		gbi_master_i.stop();
		chk("gamma bytes", 16'ha5c0, {d0, d1});
	endtask
	task automatic t_addr();
		sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc2, a1);
		gbi_master_i.byte_w(8'hc0, a2);
		gbi_master_i.stop();
		chk("foreign nacks", 16'h3, {a1, a2});
		addr_strap_pin = 1'b1;
		repeat (4) sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc2, a1);
		gbi_master_i.stop();
		chk("strap ack", 16'h0, a1);
		addr_strap_pin = 1'b0;
	endtask
	task automatic t_fifo();
		load_strobe_pin = 1'b1;
		repeat (4) sync();
		gbi_master_i.start();
		gbi_master_i.byte_w(8'hc0, a1);
		gbi_master_i.byte_w(8'h40, a2);
		for (int i = 0; i < 9; i++) begin
			gbi_master_i.byte_w(8'(i), a3);
			chk("fill ack", 16'(i == 8), a3);
		end
		gbi_master_i.stop();
		load_strobe_pin = 1'b0;
		upd_ready = 1'b1;
		for (int i = 0; i < 8; i++) begin
			chk("upd_data", {8'(8'h40 + i), 8'(i)}, upd_valid ? upd_data : 16'hxxxx);
			sync();
		end
		chk("drained", 16'h0, upd_valid);
		upd_ready = 1'b0;
	endtask
	// Clock enable freeze, then a reset in mid-run
	task automatic t_freeze();
		wr(8'h48, 8'h30);
		clk_en = 1'b0;
		bank_pin_high = 1'b1;
		repeat (4) sync();
		chk("frozen bank", 16'h0, active_bank);
		clk_en = 1'b1;
		repeat (4) sync();
		chk("pin bank", 16'h2, active_bank);
		bank_pin_high = 1'b0;
		reset_n = 1'b0;
		repeat (2) sync();
		reset_n = 1'b1;
		chk("bias_pct", gbi_pkg::PCT_100, bias_pct);
		repeat (4) sync();
		rd(8'h48, d0);
		chk("control", 16'h20, d0);
	endtask

	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		addr_strap_pin = 1'b0;
		load_strobe_pin = 1'b0;
		bank_pin_low = 1'b0;
		bank_pin_high = 1'b0;
		upd_ready = 1'b0;
		repeat (20) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (4) sync();
		t_reset();
		t_bias();
		t_bank();
		t_status();
		t_gamma();
		t_addr();
		t_fifo();
		t_freeze();
		test_done();
	end
	// About twelve times the expected run
	initial begin
		#3000000;
		mismatches++;
		test_done();
	end
endmodule // testbench
`default_nettype wire
